// file: hdl/pos_cond_pkg.sv
// constants, field layouts and carrier types of the position signal conditioning block
package pos_cond_pkg;

  // ==========================================================================
  // register indices; byte address is index times four
  localparam logic [4:0] REG_LOWPASS = 5'h00;
  localparam logic [4:0] REG_PHASE = 5'h01;
  localparam logic [4:0] REG_GAIN_FIRST = 5'h02;
  localparam logic [4:0] REG_GAIN_SECOND = 5'h03;
  localparam logic [4:0] REG_POLY_A = 5'h04;
  localparam logic [4:0] REG_POLY_B = 5'h05;
  localparam logic [4:0] REG_POLY_C = 5'h06;
  localparam logic [4:0] REG_SEL_FIRST = 5'h07;
  localparam logic [4:0] REG_SEL_SECOND = 5'h08;
  localparam logic [4:0] REG_ANGLE_REF = 5'h09;
  localparam logic [4:0] REG_FIELD_FLOOR = 5'h0A;
  localparam logic [4:0] REG_FIELD_CEIL = 5'h0B;
  localparam logic [4:0] REG_PRESHIFT = 5'h0C;
  localparam logic [4:0] REG_OUT_SCALE = 5'h0D;
  localparam logic [4:0] REG_OUT_SHIFT = 5'h0E;
  localparam logic [4:0] REG_OUT_FLOOR = 5'h0F;
  localparam logic [4:0] REG_OUT_CEIL = 5'h10;
  localparam logic [4:0] REG_NC_CORNER = 5'h11;
  localparam logic [4:0] REG_NC_THRESH = 5'h12;
  localparam int unsigned NUM_CFG = 19;
  // read-only status words
  localparam logic [4:0] REG_RESULT = 5'h14;
  localparam logic [4:0] REG_FLAGS = 5'h15;
  localparam logic [4:0] REG_ANGLE = 5'h16;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_UNITY_GAIN = 16'h4000;
  localparam logic [15:0] RST_OUT_SCALE = 16'h0200;
  localparam logic [15:0] RST_OUT_CEIL = 16'h7FFF;
  localparam logic [15:0] RST_FIELD_CEIL = 16'h7FFF;

  // ==========================================================================
  // fixed-point scaling
  localparam int unsigned FRAC_COEF = 15;
  localparam int unsigned FRAC_GAIN = 14;
  localparam int unsigned FRAC_OUT_SCALE = 9;
  localparam logic [14:0] LPF_BYPASS = 15'h0000;

  // ==========================================================================
  // flag bit positions in the flags word
  localparam int unsigned FLG_FIELD_LOW = 0;
  localparam int unsigned FLG_FIELD_HIGH = 1;
  localparam int unsigned FLG_CLAMP_LOW = 2;
  localparam int unsigned FLG_CLAMP_HIGH = 3;
  localparam int unsigned FLG_NOISE_HOLD = 4;

  typedef struct packed {
    logic signed [15:0] first;
    logic signed [15:0] second;
  } chan_pair_s;

  typedef struct packed {
    logic noise_hold;
    logic clamp_high;
    logic clamp_low;
    logic field_high;
    logic field_low;
  } flags_s;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LPF = 2'b01,
    SEQ_CORR = 2'b11,
    SEQ_OFFS = 2'b10
  } seq_e;

endpackage

// file: hdl/position_signal_conditioning.sv
// digital conditioning chain of a two-channel magnetic position sensor
//
// Behaviour
// - first-order low-pass on both channels, corner selected by a register code.
// - signed 16-bit sine coefficient corrects phase between the two channels.
// - phase coefficient zero leaves the channels unchanged.
// - each channel scaled by signed 16-bit gain, 16384 is unity.
// - offset is second-order temperature polynomial of three coefficients.
// - two selectors add the offset per channel and scale its temperature part.
// - polynomial and selector coefficients are signed 16-bit values.
// - signed 16-bit zero-position value is the angle reference point.
// - zero-position value moves the angle wrap point away from used range.
// - field magnitude outside floor or ceiling forces the output to high clamp.
// - field floor and ceiling limits are signed 16-bit values.
// - signed 16-bit pre-shift is added to the angle before output scaling.
// - output gain signed 16-bit spanning -64 to 64, unity maps full turn.
// - output offset signed 16-bit spanning -200% to 200% of full scale.
// - low and high clamp values bound the output, outside is diagnosis band.
// - noise filter smooths only while the change stays below its threshold.
// - noise threshold is negative when active, zero turns the filter off.
// - noise corner is the gain of the filter's first-order recursion.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module position_signal_conditioning (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // converter samples
  input wire logic SAMPLE_VALID_I,
  input wire pos_cond_pkg::chan_pair_s SAMPLE_I,
  input wire logic signed [15:0] TEMPERATURE_I,
  // conditioned channels to the angle calculation
  output logic COND_VALID_O,
  output pos_cond_pkg::chan_pair_s COND_O,
  // angle and magnitude from the angle calculation
  input wire logic ANGLE_VALID_I,
  input wire logic [15:0] ANGLE_I,
  input wire logic signed [15:0] MAGNITUDE_I,
  // output value
  output logic RESULT_VALID_O,
  output logic [15:0] RESULT_O,
  output pos_cond_pkg::flags_s FLAGS_O
);
  import pos_cond_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007FFF) begin
      sat16 = 16'sh7FFF;
    end else if (v < -40'sh0000008000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic logic signed [39:0] mul_shr(input logic signed [19:0] a,
                                                input logic signed [19:0] b,
                                                input int unsigned sh);
    mul_shr = (40'(a) * 40'(b)) >>> sh;
  endfunction

  // ==========================================================================
  // configuration registers and apb slave
  logic [15:0] cfg [NUM_CFG];
  logic [15:0] result_q;
  logic [15:0] angle_q;
  flags_s flags_q;
  logic [4:0] idx;
  logic mapped_cfg;
  logic mapped_ro;
  logic access;

  assign idx = PADDR_I[6:2];
  assign mapped_cfg = (PADDR_I[7] == 1'b0) && (PADDR_I[1:0] == 2'b00) &&
                      (idx < 5'(NUM_CFG));
  assign mapped_ro = (PADDR_I[7] == 1'b0) && (PADDR_I[1:0] == 2'b00) &&
                     ((idx == REG_RESULT) || (idx == REG_FLAGS) || (idx == REG_ANGLE));
  assign access = PSEL_I && PENABLE_I;

  // one wait state: pready rises in the second access cycle, drops after
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (access && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= !(mapped_cfg || (mapped_ro && !PWRITE_I));
      if (PWRITE_I || !(mapped_cfg || mapped_ro)) begin
        PRDATA_O <= 32'h0000_0000;
      end else if (mapped_cfg) begin
        PRDATA_O <= {16'h0000, cfg[idx]};
      end else if (idx == REG_RESULT) begin
        PRDATA_O <= {16'h0000, result_q};
      end else if (idx == REG_FLAGS) begin
        PRDATA_O <= {27'h0000000, flags_q};
      end else begin
        PRDATA_O <= {16'h0000, angle_q};
      end
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // settings held as 16-bit words; the low-pass code uses only bits 14:0, unsigned
  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : gen_cfg
      localparam logic [15:0] RST_VAL =
        (g == REG_GAIN_FIRST || g == REG_GAIN_SECOND) ? RST_UNITY_GAIN :
        (g == REG_OUT_SCALE) ? RST_OUT_SCALE :
        (g == REG_OUT_CEIL) ? RST_OUT_CEIL :
        (g == REG_FIELD_CEIL) ? RST_FIELD_CEIL : RST_ZERO;
      always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
          cfg[g] <= RST_VAL;
        end else if (access && PREADY_O && PWRITE_I && mapped_cfg && (idx == 5'(g))) begin
          cfg[g] <= PWDATA_I[15:0];
        end
      end
    end
  endgenerate

  logic signed [15:0] phase_coef;
  logic signed [15:0] gain_first;
  logic signed [15:0] gain_second;
  logic signed [15:0] poly_a;
  logic signed [15:0] poly_b;
  logic signed [15:0] poly_c;
  logic signed [15:0] sel_first;
  logic signed [15:0] sel_second;
  logic signed [15:0] field_floor;
  logic signed [15:0] field_ceil;
  logic signed [15:0] out_scale;
  logic signed [15:0] out_shift;
  logic signed [15:0] out_floor;
  logic signed [15:0] out_ceil;
  logic signed [15:0] nc_corner;
  logic signed [15:0] nc_thresh;

  assign phase_coef = cfg[REG_PHASE];
  assign gain_first = cfg[REG_GAIN_FIRST];
  assign gain_second = cfg[REG_GAIN_SECOND];
  assign poly_a = cfg[REG_POLY_A];
  assign poly_b = cfg[REG_POLY_B];
  assign poly_c = cfg[REG_POLY_C];
  assign sel_first = cfg[REG_SEL_FIRST];
  assign sel_second = cfg[REG_SEL_SECOND];
  assign field_floor = cfg[REG_FIELD_FLOOR];
  assign field_ceil = cfg[REG_FIELD_CEIL];
  assign out_scale = cfg[REG_OUT_SCALE];
  assign out_shift = cfg[REG_OUT_SHIFT];
  assign out_floor = cfg[REG_OUT_FLOOR];
  assign out_ceil = cfg[REG_OUT_CEIL];
  assign nc_corner = cfg[REG_NC_CORNER];
  assign nc_thresh = cfg[REG_NC_THRESH];

  // ==========================================================================
  // channel sequencer: one sample takes four cycles, samples while busy are dropped
  seq_e state;
  seq_e next_state;
  chan_pair_s raw_q;
  chan_pair_s lpf_q;
  chan_pair_s corr_q;
  logic signed [15:0] temp_q;
  logic [14:0] lpf_coef;

  assign lpf_coef = cfg[REG_LOWPASS][14:0];

  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: begin
        if (SAMPLE_VALID_I) begin
          next_state = SEQ_LPF;
        end
      end
      SEQ_LPF: next_state = SEQ_CORR;
      SEQ_CORR: next_state = SEQ_OFFS;
      SEQ_OFFS: next_state = SEQ_IDLE;
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state <= SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      raw_q <= '0;
      temp_q <= 16'sh0000;
    end else if (state == SEQ_IDLE && SAMPLE_VALID_I) begin
      raw_q <= SAMPLE_I;
      temp_q <= TEMPERATURE_I;
    end
  end

  // code zero bypasses, small codes give the lowest corner
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      lpf_q <= '0;
    end else if (state == SEQ_LPF) begin
      if (lpf_coef == LPF_BYPASS) begin
        lpf_q <= raw_q;
      end else begin
        lpf_q.first <= sat16(40'(lpf_q.first) + mul_shr(20'(raw_q.first) - 20'(lpf_q.first),
                             20'($signed({1'b0, lpf_coef})), FRAC_COEF));
        lpf_q.second <= sat16(40'(lpf_q.second) + mul_shr(20'(raw_q.second) -
                              20'(lpf_q.second), 20'($signed({1'b0, lpf_coef})),
                              FRAC_COEF));
      end
    end
  end

  // second channel loses the sine share of the first; gain fix is software's job
  logic signed [39:0] phased_second;
  assign phased_second = 40'(lpf_q.second) -
                         mul_shr(20'(lpf_q.first), 20'(phase_coef), FRAC_COEF);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      corr_q <= '0;
    end else if (state == SEQ_CORR) begin
      corr_q.first <= sat16(mul_shr(20'(lpf_q.first), 20'(gain_first), FRAC_GAIN));
      corr_q.second <= sat16(mul_shr(20'(sat16(phased_second)), 20'(gain_second),
                             FRAC_GAIN));
    end
  end

  // temperature polynomial; constant part fixed, drift part scaled per channel
  logic signed [39:0] temp_sq;
  logic signed [39:0] drift;
  logic signed [39:0] offs_first;
  logic signed [39:0] offs_second;

  assign temp_sq = mul_shr(20'(temp_q), 20'(temp_q), FRAC_COEF);
  assign drift = mul_shr(20'(poly_b), 20'(temp_q), FRAC_COEF) +
                 mul_shr(20'(poly_c), 20'(sat16(temp_sq)), FRAC_COEF);
  assign offs_first = (sel_first == 16'sh0000) ? 40'sh0 :
                      40'(poly_a) + mul_shr(20'(sel_first), 20'(sat16(drift)),
                                            FRAC_COEF);
  assign offs_second = (sel_second == 16'sh0000) ? 40'sh0 :
                       40'(poly_a) + mul_shr(20'(sel_second), 20'(sat16(drift)),
                                             FRAC_COEF);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      COND_VALID_O <= 1'b0;
      COND_O <= '0;
    end else begin
      COND_VALID_O <= (state == SEQ_OFFS);
      if (state == SEQ_OFFS) begin
        COND_O.first <= sat16(40'(corr_q.first) + offs_first);
        COND_O.second <= sat16(40'(corr_q.second) + offs_second);
      end
    end
  end

  // ==========================================================================
  // output chain: shift, scale, clamp, noise filter, field override
  logic stage_a;
  logic stage_b;
  logic [14:0] shifted_q;
  logic field_low_q;
  logic field_high_q;
  logic field_bad_b;
  logic signed [15:0] clamped_q;
  logic clamp_low_q;
  logic clamp_high_q;
  logic [15:0] next_shifted;

  // modular 15-bit angle: reference moves the wrap point
  assign next_shifted = ANGLE_I - cfg[REG_ANGLE_REF] + cfg[REG_PRESHIFT];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      stage_a <= 1'b0;
      shifted_q <= 15'h0000;
      field_low_q <= 1'b0;
      field_high_q <= 1'b0;
    end else begin
      stage_a <= ANGLE_VALID_I;
      if (ANGLE_VALID_I) begin
        shifted_q <= next_shifted[14:0];
        field_low_q <= MAGNITUDE_I < field_floor;
        field_high_q <= MAGNITUDE_I > field_ceil;
      end
    end
  end

  // 512 is unity gain; offset code counts two units of output scale
  logic signed [39:0] scaled;
  assign scaled = mul_shr(20'($signed({1'b0, shifted_q})), 20'(out_scale),
                          FRAC_OUT_SCALE) + 40'(out_shift) * 40'sd2;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      stage_b <= 1'b0;
      clamped_q <= 16'sh0000;
      clamp_low_q <= 1'b0;
      clamp_high_q <= 1'b0;
      field_bad_b <= 1'b0;
    end else begin
      stage_b <= stage_a;
      if (stage_a) begin
        field_bad_b <= field_low_q || field_high_q;
        // saturate instead of wrapping so large gains cannot fold back
        if (scaled < 40'(out_floor)) begin
          clamped_q <= out_floor;
          clamp_low_q <= 1'b1;
          clamp_high_q <= 1'b0;
        end else if (scaled > 40'(out_ceil)) begin
          clamped_q <= out_ceil;
          clamp_low_q <= 1'b0;
          clamp_high_q <= 1'b1;
        end else begin
          clamped_q <= scaled[15:0];
          clamp_low_q <= 1'b0;
          clamp_high_q <= 1'b0;
        end
      end
    end
  end

  // noise filter: recursion only for small steps, large steps pass at once
  logic signed [15:0] nc_q;
  logic signed [16:0] nc_diff;
  logic [16:0] nc_abs;
  logic [16:0] nc_limit;
  logic nc_small;
  logic signed [15:0] next_nc;

  assign nc_diff = 17'(clamped_q) - 17'(nc_q);
  assign nc_abs = nc_diff[16] ? 17'(-nc_diff) : 17'(nc_diff);
  assign nc_limit = 17'(-17'(nc_thresh));
  assign nc_small = (nc_thresh < 16'sh0000) && (nc_abs < nc_limit);
  assign next_nc = nc_small ?
                   sat16(40'(nc_q) + mul_shr(20'(nc_diff), 20'(nc_corner), FRAC_COEF)) :
                   clamped_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      nc_q <= 16'sh0000;
    end else if (stage_b) begin
      nc_q <= next_nc;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RESULT_VALID_O <= 1'b0;
      RESULT_O <= 16'h0000;
      FLAGS_O <= '0;
      result_q <= 16'h0000;
      flags_q <= '0;
      angle_q <= 16'h0000;
    end else begin
      RESULT_VALID_O <= stage_b;
      if (stage_b) begin
        // field out of range overrides everything, noise filter included
        RESULT_O <= field_bad_b ? out_ceil : next_nc;
        result_q <= field_bad_b ? out_ceil : next_nc;
        FLAGS_O <= '{noise_hold: nc_small, clamp_high: clamp_high_q || field_bad_b,
                     clamp_low: clamp_low_q && !field_bad_b, field_high: field_high_q,
                     field_low: field_low_q};
        flags_q <= '{noise_hold: nc_small, clamp_high: clamp_high_q || field_bad_b,
                     clamp_low: clamp_low_q && !field_bad_b, field_high: field_high_q,
                     field_low: field_low_q};
      end
      if (stage_a) begin
        angle_q <= {1'b0, shifted_q};
      end
    end
  end

endmodule

`default_nettype wire

// file: bench/pos_cond_checker.sv
// port-level assertion checker for the position signal conditioning block
`timescale 1ns/1ps
`default_nettype none

module pos_cond_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // streams
  input wire logic SAMPLE_VALID_I,
  input wire logic COND_VALID_O,
  input wire pos_cond_pkg::chan_pair_s COND_O,
  input wire logic ANGLE_VALID_I,
  input wire logic RESULT_VALID_O,
  input wire logic [15:0] RESULT_O,
  input wire pos_cond_pkg::flags_s FLAGS_O
);
  import pos_cond_pkg::*;
  // ==========================================================================
  // address decode
  logic bad_addr;
  // status words are read only, so a write there counts as refused
  assign bad_addr = (PADDR_I[1:0] != 2'b00) || (PADDR_I > 8'h58) || (PADDR_I == 8'h4C)
    || (PWRITE_I && PADDR_I >= 8'h50);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // ==========================================================================
  // assertions
  a_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready not one cycle after access start");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_err_refuse: assert property (PREADY_O && bad_addr |-> PSLVERR_O)
    else $error("bad access not refused");
  a_err_data: assert property (PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h00000000)
    else $error("refused read data not zero");
  a_good_addr: assert property (PREADY_O && !bad_addr |->
    !PSLVERR_O && PRDATA_O[31:16] == 16'h0000)
    else $error("good access refused or upper half set");
  a_cond_latency: assert property (COND_VALID_O |-> $past(SAMPLE_VALID_I, 4))
    else $error("conditioned pair without sample four cycles before");
  a_cond_spacing: assert property (COND_VALID_O |=> !COND_VALID_O [*3])
    else $error("conditioned pairs closer than four cycles");
  a_result_pipe: assert property (ANGLE_VALID_I |-> ##3 RESULT_VALID_O)
    else $error("result missing three cycles after angle");
  a_result_hold: assert property (!RESULT_VALID_O |->
    $stable(RESULT_O) && $stable(FLAGS_O))
    else $error("result changed without valid");
  a_field_override: assert property (RESULT_VALID_O &&
    (FLAGS_O.field_low || FLAGS_O.field_high) |-> FLAGS_O.clamp_high && !FLAGS_O.clamp_low)
    else $error("field out of range without high clamp");

  c_refused: cover property (PREADY_O && PSLVERR_O);
  c_cond: cover property (COND_VALID_O);
  c_field: cover property (RESULT_VALID_O && FLAGS_O.field_low);
endmodule

bind position_signal_conditioning pos_cond_checker chk_u (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .SAMPLE_VALID_I(SAMPLE_VALID_I), .COND_VALID_O(COND_VALID_O),
  .COND_O(COND_O), .ANGLE_VALID_I(ANGLE_VALID_I), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_O(RESULT_O), .FLAGS_O(FLAGS_O));

`default_nettype wire

// file: bench/sense_front_end.sv
// model of the converters and angle calculation that feed the block
`timescale 1ns/1ps
`default_nettype none

module sense_front_end (
  // clock
  input wire logic clk_i,
  // converter samples
  output logic sample_valid_o,
  output pos_cond_pkg::chan_pair_s sample_o,
  output logic signed [15:0] temperature_o,
  // angle calculation results
  output logic angle_valid_o,
  output logic [15:0] angle_o,
  output logic signed [15:0] magnitude_o
);
  import pos_cond_pkg::*;
  initial begin
    sample_valid_o = 1'b0;
    sample_o = '0;
    temperature_o = 16'h0000;
    angle_valid_o = 1'b0;
    angle_o = 16'h0000;
    magnitude_o = 16'h0000;
  end

  // ==========================================================================
  // one-cycle frames; data inverts afterwards so a late capture shows up
  task automatic send_sample(input logic [15:0] f, s, t);
    @(posedge clk_i);
    sample_valid_o <= 1'b1;
    sample_o <= {f, s};
    temperature_o <= t;
    @(posedge clk_i);
    sample_valid_o <= 1'b0;
    // temperature is a live measurement and stays put
    sample_o <= ~{f, s};
  endtask

  task automatic send_angle(input logic [15:0] a, m);
    @(posedge clk_i);
    angle_valid_o <= 1'b1;
    angle_o <= a;
    magnitude_o <= m;
    @(posedge clk_i);
    angle_valid_o <= 1'b0;
    angle_o <= ~a;
    magnitude_o <= ~m;
  endtask
endmodule

`default_nettype wire

// file: bench/tb.sv
// self-checking bench of the position signal conditioning block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module tb;
  import pos_cond_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, err_v, svalid, cvalid, avalid, rvalid;
  chan_pair_s smp, cond;
  logic [15:0] temp, ang, mag, res;
  flags_s flg;
  int num_errors = 0;
  int cmp_count = 0;
  int cond_cnt = 0, res_cnt = 0, cyc = 0, c0v;
  logic [15:0] rstv [19] = '{16'h0000, 16'h0000, 16'h4000, 16'h4000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7FFF, 16'h0000, 16'h0200,
    16'h0000, 16'h0000, 16'h7FFF, 16'h0000, 16'h0000};

  always #5 clk = ~clk;

  position_signal_conditioning dut_u (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SAMPLE_VALID_I(svalid),
    .SAMPLE_I(smp), .TEMPERATURE_I(temp), .COND_VALID_O(cvalid), .COND_O(cond),
    .ANGLE_VALID_I(avalid), .ANGLE_I(ang), .MAGNITUDE_I(mag), .RESULT_VALID_O(rvalid),
    .RESULT_O(res), .FLAGS_O(flg));

  sense_front_end fe_u (.clk_i(clk), .sample_valid_o(svalid), .sample_o(smp),
    .temperature_o(temp), .angle_valid_o(avalid), .angle_o(ang), .magnitude_o(mag));

  // ==========================================================================
  // pulse counters and watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cvalid === 1'b1) cond_cnt <= cond_cnt + 1;
    if (rvalid === 1'b1) res_cnt <= res_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // apb master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] i, input logic [15:0] d);
    apb(1'b1, {1'b0, i, 2'b00}, d);
    `CHK("write_err", 1'b0, err_v)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 16'h0000);
    `CHK("prdata", e, rd_v)
    `CHK("pslverr", ee, err_v)
  endtask

  // ==========================================================================
  // stream checks; outputs hold, so the value is read after the pulse
  task automatic samp(input logic [15:0] f, s, t, ef, es);
    int c0, n;
    c0 = cond_cnt;
    n = 0;
    fe_u.send_sample(f, s, t);
    while (cond_cnt == c0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("cond_seen", 1'b1, cond_cnt != c0)
    `CHK("cond", {ef, es}, cond)
  endtask

  task automatic angl(input logic [15:0] a, m, e, input logic [3:0] ef);
    int c0, n;
    c0 = res_cnt;
    n = 0;
    fe_u.send_angle(a, m);
    while (res_cnt == c0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("res_seen", 1'b1, res_cnt != c0)
    `CHK("result", e, res)
    `CHK("flags", ef, flg[3:0])
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_CFG; i++) rchk(8'(i * 4), {16'h0000, rstv[i]}, 1'b0);
    for (int i = 0; i < NUM_CFG; i++) wreg(5'(i), 16'hC3A0 + 16'(i));
    for (int i = 0; i < NUM_CFG; i++) rchk(8'(i * 4), {16'h0000, 16'hC3A0 + 16'(i)},
      1'b0);
    for (int i = 0; i < NUM_CFG; i++) wreg(5'(i), rstv[i]);
    rchk(8'h4C, 32'h00000000, 1'b1);
    rchk(8'h06, 32'h00000000, 1'b1);
    rchk(8'h5C, 32'h00000000, 1'b1);
    apb(1'b1, 8'h50, 16'h1234);
    `CHK("ro_write_err", 1'b1, err_v)
    // ========================================================================
    // sample chain
    samp(16'h03E8, 16'hF830, 16'h0000, 16'h03E8, 16'hF830);
    wreg(REG_GAIN_FIRST, 16'h2000);
    wreg(REG_GAIN_SECOND, 16'hC000);
    samp(16'h03E8, 16'hF830, 16'h0000, 16'h01F4, 16'h07D0);
    wreg(REG_GAIN_FIRST, 16'h4000);
    wreg(REG_PHASE, 16'h4000);
    wreg(REG_GAIN_SECOND, 16'h49E7);
    samp(16'h03E8, 16'h0000, 16'h0000, 16'h03E8, 16'hFDBE);
    wreg(REG_PHASE, 16'h0000);
    wreg(REG_GAIN_SECOND, 16'h4000);
    wreg(REG_POLY_A, 16'h0064);
    wreg(REG_POLY_B, 16'h4000);
    wreg(REG_POLY_C, 16'h4000);
    wreg(REG_SEL_SECOND, 16'h4000);
    samp(16'h03E8, 16'h07D0, 16'h03E8, 16'h03E8, 16'h0935);
    wreg(REG_SEL_SECOND, 16'h0000);
    samp(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wreg(REG_LOWPASS, 16'h4000);
    samp(16'h03E8, 16'h07D0, 16'h0000, 16'h01F4, 16'h03E8);
    samp(16'h03E8, 16'h07D0, 16'h0000, 16'h02EE, 16'h05DC);
    wreg(REG_LOWPASS, 16'h0000);
    c0v = cond_cnt;
    fe_u.send_sample(16'h000B, 16'h0016, 16'h0000);
    fe_u.send_sample(16'h0021, 16'h002C, 16'h0000);
    repeat (12) @(posedge clk);
    `CHK("cond_count", c0v + 1, cond_cnt)
    `CHK("cond_kept", 32'h000B0016, cond)
    // ========================================================================
    // angle chain
    angl(16'h03E8, 16'h01F4, 16'h03E8, 4'h0);
    rchk({1'b0, REG_RESULT, 2'b00}, 32'h000003E8, 1'b0);
    wreg(REG_ANGLE_REF, 16'h0064);
    wreg(REG_PRESHIFT, 16'h0032);
    angl(16'h03E8, 16'h01F4, 16'h03B6, 4'h0);
    angl(16'h0014, 16'h01F4, 16'h7FE2, 4'h0);
    rchk({1'b0, REG_ANGLE, 2'b00}, 32'h00007FE2, 1'b0);
    wreg(REG_ANGLE_REF, 16'h0000);
    wreg(REG_PRESHIFT, 16'h0000);
    wreg(REG_OUT_SCALE, 16'h0400);
    angl(16'h4E20, 16'h01F4, 16'h7FFF, 4'h8);
    wreg(REG_OUT_SCALE, 16'h0200);
    wreg(REG_OUT_SHIFT, 16'hFF9C);
    angl(16'h03E8, 16'h01F4, 16'h0320, 4'h0);
    wreg(REG_OUT_FLOOR, 16'h0384);
    angl(16'h03E8, 16'h01F4, 16'h0384, 4'h4);
    wreg(REG_OUT_SHIFT, 16'h8000);
    angl(16'h03E8, 16'h01F4, 16'h0384, 4'h4);
    wreg(REG_OUT_SHIFT, 16'h0000);
    wreg(REG_OUT_FLOOR, 16'h0000);
    wreg(REG_OUT_CEIL, 16'h7000);
    wreg(REG_FIELD_FLOOR, 16'h0064);
    angl(16'h03E8, 16'h0032, 16'h7000, 4'h9);
    angl(16'h03E8, 16'h0064, 16'h03E8, 4'h0);
    wreg(REG_FIELD_FLOOR, 16'h0000);
    wreg(REG_FIELD_CEIL, 16'h03E8);
    angl(16'h03E8, 16'h03E9, 16'h7000, 4'hA);
    rchk({1'b0, REG_FLAGS, 2'b00}, 32'h0000000A, 1'b0);
    wreg(REG_FIELD_CEIL, 16'h7FFF);
    wreg(REG_OUT_CEIL, 16'h7FFF);
    wreg(REG_NC_CORNER, 16'h2000);
    wreg(REG_NC_THRESH, 16'hFF9C);
    angl(16'h1388, 16'h01F4, 16'h1388, 4'h0);
    angl(16'h13B0, 16'h01F4, 16'h1392, 4'h0);
    `CHK("noise_hold", 1'b1, flg.noise_hold)
    angl(16'h1B58, 16'h01F4, 16'h1B58, 4'h0);
    wreg(REG_NC_THRESH, 16'h0000);
    angl(16'h1B6C, 16'h01F4, 16'h1B6C, 4'h0);
    summarize();
  end
endmodule

`default_nettype wire
